// [core/chgirq_edge.sv]
// Rising edge detector for a vector of comparator condition levels
`timescale 1ns/10ps
`default_nettype none
module chgirq_edge #(
  parameter int unsigned W = 16
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         reset_n_i,
  // Levels and one-cycle rising pulses
  input  wire logic [W-1:0] level_i,
  output logic      [W-1:0] rise_o
);

  logic [W-1:0] prev;

  // Previous level resets low so a condition already true at release counts as an edge
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      prev <= '0;
    end else begin
      prev <= level_i;
    end
  end

  assign rise_o = level_i & ~prev;

endmodule : chgirq_edge
`default_nettype wire

// [core/chgirq_pkg.sv]
// Constants, types and helpers shared by the charger interrupt status and mask block
package chgirq_pkg;

  // Register data width and the Wishbone slave widths
  localparam int unsigned CHGIRQ_DW      = 16;
  localparam int unsigned CHGIRQ_AW      = 10;
  localparam int unsigned CHGIRQ_BUS_DW  = 32;
  localparam int unsigned CHGIRQ_SEL_W   = 4;

  // Register indices; the byte address is four times the index
  localparam logic [7:0] CHGIRQ_STATUS_IDX = 8'h19;
  localparam logic [7:0] CHGIRQ_MASK_IDX   = 8'h21;
  localparam logic [7:0] CHGIRQ_PEND_IDX   = 8'h22;
  localparam logic [7:0] CHGIRQ_LEVEL_IDX  = 8'h23;

  // Status bit positions
  localparam int unsigned CHGIRQ_BIT_2V85    = 0;
  localparam int unsigned CHGIRQ_BIT_3V1     = 1;
  localparam int unsigned CHGIRQ_FIRST_OTHER = 2;
  localparam int unsigned CHGIRQ_OTHER_W     = CHGIRQ_DW - CHGIRQ_FIRST_OTHER;

  // Reset values
  localparam logic [15:0] CHGIRQ_STATUS_RST = 16'h0000;
  localparam logic [15:0] CHGIRQ_MASK_RST   = 16'hffff;
  localparam logic [31:0] CHGIRQ_RDATA_RST  = 32'h0000_0000;
  localparam logic [15:0] CHGIRQ_ZERO16     = 16'h0000;

  // Bus slave sequencing
  typedef enum logic {
    CHGIRQ_BUS_IDLE,
    CHGIRQ_BUS_ACK
  } chgirq_bus_state_t;

  // True when a byte address selects the register at a given index
  function automatic logic reg_hit(input logic [CHGIRQ_AW-1:0] adr, input logic [7:0] idx);
    reg_hit = (adr[CHGIRQ_AW-1:2] == idx) && (adr[1:0] == 2'h0);
  endfunction : reg_hit

  // Merge write data into a 16-bit register, honouring byte lanes 0 and 1
  function automatic logic [15:0] apply_sel(input logic [15:0] old_v,
                                            input logic [15:0] new_v,
                                            input logic [3:0]  sel);
    apply_sel[7:0]  = sel[0] ? new_v[7:0]  : old_v[7:0];
    apply_sel[15:8] = sel[1] ? new_v[15:8] : old_v[15:8];
  endfunction : apply_sel

endpackage : chgirq_pkg

// [core/chgirq_top.sv]
// Charger interrupt status, mask and summary interrupt with a Wishbone register slave
//
// Contract
// RQ1 - Below 3.1 V rising edge sets bit 1
// RQ2 - Below 2.85 V rising edge sets bit 0
// RQ3 - Status read returns bits, then clears them
// RQ4 - Sixteen mask bits; one suppresses matching status
// RQ5 - Interrupt only for set, unmasked status bits
// RQ6 - Interrupt drops once no unmasked bit remains
//
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module chgirq_top (
  // Clock and reset
  input  wire logic        SYS_CLK_I,
  input  wire logic        RESET_N_I,
  // Wishbone slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [9:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  // Comparator condition levels
  input  wire logic        BATT_BELOW_3V1_I,
  input  wire logic        BATT_BELOW_2V85_I,
  input  wire logic [13:0] CHG_OTHER_COND_I,
  // Summary interrupt
  output logic             CHARGER_SUMMARY_IRQ_O
);

  localparam int unsigned DW = chgirq_pkg::CHGIRQ_DW;

  logic [DW-1:0] status;
  logic [DW-1:0] mask;
  logic [DW-1:0] next_status;
  logic [DW-1:0] next_mask;
  logic [31:0]   next_rdata;
  logic          irq;
  logic          next_irq;

  wire  logic [DW-1:0] cond_level;
  wire  logic [DW-1:0] rise;
  wire  logic          take;
  wire  logic          ack;

  // Condition vector in status bit order
  assign cond_level[chgirq_pkg::CHGIRQ_BIT_2V85] = BATT_BELOW_2V85_I;
  assign cond_level[chgirq_pkg::CHGIRQ_BIT_3V1]  = BATT_BELOW_3V1_I;
  assign cond_level[DW-1:chgirq_pkg::CHGIRQ_FIRST_OTHER] = CHG_OTHER_COND_I;

  // Only the false-to-true transition of a condition, or a condition already true at reset release, raises an event
  chgirq_edge #(
    .W         (DW)
  ) u_edge (
    .clk_i     (SYS_CLK_I),
    .reset_n_i (RESET_N_I),
    .level_i   (cond_level),
    .rise_o    (rise)
  );

  chgirq_wbs u_wbs (
    .clk_i     (SYS_CLK_I),
    .reset_n_i (RESET_N_I),
    .cyc_i     (WB_CYC_I),
    .stb_i     (WB_STB_I),
    .take_o    (take),
    .ack_o     (ack)
  );

  assign WB_ACK_O = ack;

  // Address decode
  wire logic hit_status = chgirq_pkg::reg_hit(WB_ADR_I, chgirq_pkg::CHGIRQ_STATUS_IDX);
  wire logic hit_mask   = chgirq_pkg::reg_hit(WB_ADR_I, chgirq_pkg::CHGIRQ_MASK_IDX);
  wire logic hit_pend   = chgirq_pkg::reg_hit(WB_ADR_I, chgirq_pkg::CHGIRQ_PEND_IDX);
  wire logic hit_level  = chgirq_pkg::reg_hit(WB_ADR_I, chgirq_pkg::CHGIRQ_LEVEL_IDX);

  wire logic rd_take    = take && !WB_WE_I;
  wire logic wr_take    = take && WB_WE_I;
  wire logic rd_status  = rd_take && hit_status;
  wire logic wr_status  = wr_take && hit_status;
  wire logic wr_mask    = wr_take && hit_mask;

  // Bits returned by a status read are exactly the bits it clears
  wire logic [DW-1:0] rd_clr = rd_status ? status : chgirq_pkg::CHGIRQ_ZERO16; // RQ3

  // Software may also clear a bit by writing a one to it
  wire logic [DW-1:0] w1c_clr = wr_status ?
    chgirq_pkg::apply_sel(chgirq_pkg::CHGIRQ_ZERO16, WB_DAT_I[DW-1:0], WB_SEL_I) :
    chgirq_pkg::CHGIRQ_ZERO16;

  wire logic [DW-1:0] pending = status & ~mask; // RQ5

  // A new edge in the clearing cycle is kept: set wins over clear
  assign next_status = (status & ~(rd_clr | w1c_clr)) | rise; // RQ1 RQ2 RQ3

  assign next_mask = wr_mask ? // RQ4
    chgirq_pkg::apply_sel(mask, WB_DAT_I[DW-1:0], WB_SEL_I) : mask;

  // Interrupt follows the register contents it will show next cycle
  assign next_irq = |(next_status & ~next_mask); // RQ5 RQ6

  // Read data; unmapped addresses read as zero and writes to them are dropped
  wire logic [DW-1:0] rd_word =
    hit_status ? status :
    hit_mask   ? mask :
    hit_pend   ? pending :
    hit_level  ? cond_level :
    chgirq_pkg::CHGIRQ_ZERO16;

  assign next_rdata = rd_take ? {chgirq_pkg::CHGIRQ_ZERO16, rd_word} : chgirq_pkg::CHGIRQ_RDATA_RST;

  always_ff @(posedge SYS_CLK_I) begin
    if (!RESET_N_I) begin
      status <= chgirq_pkg::CHGIRQ_STATUS_RST;
      mask   <= chgirq_pkg::CHGIRQ_MASK_RST;
      irq    <= 1'b0;
    end else begin
      status <= next_status;
      mask   <= next_mask;
      irq    <= next_irq;
    end
  end

  // Read data is loaded with the acknowledge and held until the next access
  always_ff @(posedge SYS_CLK_I) begin
    if (!RESET_N_I) begin
      WB_DAT_O <= chgirq_pkg::CHGIRQ_RDATA_RST;
    end else if (take) begin
      WB_DAT_O <= next_rdata;
    end
  end

  assign CHARGER_SUMMARY_IRQ_O = irq;

  // Checks next to the status latch

  property p_set_3v1;
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
      rise[chgirq_pkg::CHGIRQ_BIT_3V1] |=> status[chgirq_pkg::CHGIRQ_BIT_3V1];
  endproperty
  a_set_3v1: assert property (p_set_3v1) // RQ1
    else $error("below 3.1 V edge did not set status bit 1");

  property p_hold_3v1;
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
      (status[chgirq_pkg::CHGIRQ_BIT_3V1] && !take)
        |=> status[chgirq_pkg::CHGIRQ_BIT_3V1] [*1] ##0 $stable(status[chgirq_pkg::CHGIRQ_BIT_3V1]);
  endproperty
  a_hold_3v1: assert property (p_hold_3v1) // RQ1
    else $error("status bit 1 dropped without a host access");

  property p_set_2v85;
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
      (BATT_BELOW_2V85_I && !$past(BATT_BELOW_2V85_I) && $past(RESET_N_I))
        |=> status[chgirq_pkg::CHGIRQ_BIT_2V85];
  endproperty
  a_set_2v85: assert property (p_set_2v85) // RQ2
    else $error("below 2.85 V edge did not set status bit 0");

  property p_no_level_set;
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
      (rd_status && $past(BATT_BELOW_2V85_I) && BATT_BELOW_2V85_I)
        |=> !status[chgirq_pkg::CHGIRQ_BIT_2V85];
  endproperty
  a_no_level_set: assert property (p_no_level_set) // RQ2
    else $error("a steady low-battery level re-set status bit 0");

  property p_no_level_3v1;
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
      (rd_status && $past(BATT_BELOW_3V1_I) && BATT_BELOW_3V1_I)
        |=> !status[chgirq_pkg::CHGIRQ_BIT_3V1];
  endproperty
  a_no_level_3v1: assert property (p_no_level_3v1) // RQ1
    else $error("a steady low-battery level re-set status bit 1");

  // A bit may only appear where the detector saw an edge; a steady level sets one only if already high at reset release
  property p_set_only_edge;
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
      RESET_N_I |=> ((status & ~$past(status) & ~$past(rise)) == chgirq_pkg::CHGIRQ_ZERO16);
  endproperty
  a_set_only_edge: assert property (p_set_only_edge) // RQ2
    else $error("a status bit was set without a rising condition");

  // Checks on the read-to-clear path

  property p_read_clear;
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
      rd_status |=> (WB_DAT_O[15:0] == $past(status)) && (status == $past(rise)) && WB_ACK_O;
  endproperty
  a_read_clear: assert property (p_read_clear) // RQ3
    else $error("status read returned wrong bits or did not clear them");

  // Reads of other registers must not lose events
  property p_clear_only_by_host;
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
      (!rd_status && !wr_status) |=> ((status & $past(status)) == $past(status));
  endproperty
  a_clear_only_by_host: assert property (p_clear_only_by_host) // RQ3
    else $error("a status bit dropped without a status access");

  property p_w1c;
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
      wr_status |=> ((status & $past(w1c_clr & ~rise)) == chgirq_pkg::CHGIRQ_ZERO16);
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("writing a one did not clear the status bit");

  // Checks on the mask, pending and level registers

  property p_mask_write;
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
      (wr_mask && WB_SEL_I[1:0] == 2'h3) |=> ##1 (mask == $past(WB_DAT_I[15:0], 2));
  endproperty
  a_mask_write: assert property (p_mask_write) // RQ4
    else $error("mask register did not take the written sixteen bits");

  property p_mask_read;
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
      (rd_take && hit_mask) |=> (WB_DAT_O[15:0] == $past(mask));
  endproperty
  a_mask_read: assert property (p_mask_read) // RQ4
    else $error("mask read returned a value other than the register");

  property p_mask_hold;
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
      !wr_mask |=> (mask == $past(mask));
  endproperty
  a_mask_hold: assert property (p_mask_hold) // RQ4
    else $error("mask register changed without a mask write");

  // Byte lanes let software touch half the mask without a read-modify-write
  property p_mask_lanes;
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
      (wr_mask && WB_SEL_I[1:0] == 2'h2)
        |=> (mask[7:0] == $past(mask[7:0])) && (mask[15:8] == $past(WB_DAT_I[15:8]));
  endproperty
  a_mask_lanes: assert property (p_mask_lanes) // RQ4
    else $error("mask write did not honour the byte lanes");

  property p_pend_read;
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
      (rd_take && hit_pend) |=> (WB_DAT_O[15:0] == $past(status & ~mask));
  endproperty
  a_pend_read: assert property (p_pend_read) // RQ5
    else $error("pending read disagrees with unmasked status bits");

  property p_level_read;
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
      (rd_take && hit_level) |=> (WB_DAT_O[15:0] == $past(cond_level));
  endproperty
  a_level_read: assert property (p_level_read) // RQ1
    else $error("level read disagrees with the condition inputs");

  // Checks on the summary interrupt

  property p_irq_level;
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
      $past(RESET_N_I) |-> (CHARGER_SUMMARY_IRQ_O == (|(status & ~mask)));
  endproperty
  a_irq_level: assert property (p_irq_level) // RQ5
    else $error("summary interrupt disagrees with unmasked status bits");

  property p_irq_drop;
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
      (rd_status && ((rise & ~mask) == chgirq_pkg::CHGIRQ_ZERO16) && !wr_mask)
        |=> !CHARGER_SUMMARY_IRQ_O;
  endproperty
  a_irq_drop: assert property (p_irq_drop) // RQ6
    else $error("summary interrupt stayed high after status was read out");

  property p_irq_mask_off;
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
      (wr_mask && WB_SEL_I[1:0] == 2'h3 && WB_DAT_I[15:0] == 16'hffff)
        |=> !CHARGER_SUMMARY_IRQ_O;
  endproperty
  a_irq_mask_off: assert property (p_irq_mask_off) // RQ6
    else $error("summary interrupt stayed high with every bit masked");

  // Checks on the bus handshake

  property p_ack_pulse;
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
      take |=> WB_ACK_O ##1 !WB_ACK_O;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("acknowledge was not a single cycle after the request");

  property p_dat_upper;
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
      WB_ACK_O |-> (WB_DAT_O[31:16] == chgirq_pkg::CHGIRQ_ZERO16);
  endproperty
  a_dat_upper: assert property (p_dat_upper)
    else $error("unused upper read data lanes were not zero");

  property p_ack_cause;
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
      WB_ACK_O |-> $past(take);
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("acknowledge without a taken request");

endmodule : chgirq_top
`default_nettype wire

// [core/chgirq_wbs.sv]
// Classic Wishbone slave handshake: request acceptance and one-cycle acknowledge
`timescale 1ns/10ps
`default_nettype none
module chgirq_wbs (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  // Bus request
  input  wire logic cyc_i,
  input  wire logic stb_i,
  // Handshake
  output logic      take_o,
  output logic      ack_o
);

  chgirq_pkg::chgirq_bus_state_t state;
  chgirq_pkg::chgirq_bus_state_t next_state;

  // A request is taken only from idle, so a request still held after the acknowledge is taken again
  assign take_o = (state == chgirq_pkg::CHGIRQ_BUS_IDLE) && cyc_i && stb_i;
  assign ack_o  = (state == chgirq_pkg::CHGIRQ_BUS_ACK);

  always_comb begin
    next_state = state;
    unique case (state)
      chgirq_pkg::CHGIRQ_BUS_IDLE: begin
        if (take_o) begin
          next_state = chgirq_pkg::CHGIRQ_BUS_ACK;
        end
      end
      chgirq_pkg::CHGIRQ_BUS_ACK: begin
        next_state = chgirq_pkg::CHGIRQ_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state <= chgirq_pkg::CHGIRQ_BUS_IDLE;
    end else begin
      state <= next_state;
    end
  end

endmodule : chgirq_wbs
`default_nettype wire

// [dv/chgirq_host.sv]
// Wishbone classic host model that reaches the charger interrupt registers
`timescale 1ns/10ps
`default_nettype none
module chgirq_host (
  // Clock
  input  wire logic        clk_i,
  // Wishbone master
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic      [9:0]  adr_o,
  output logic      [3:0]  sel_o,
  output logic      [31:0] dat_o,
  input  wire logic [31:0] dat_i,
  input  wire logic        ack_i
);
  initial begin
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
  end

  // One classic cycle; the request stands until ack is sampled high
  task automatic xfer(input logic w, input logic [9:0] a, input logic [3:0] s,
                      input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'b11, w, a, s, wd};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 16);
    rd = dat_i;
    {cyc_o, stb_o, we_o} <= 3'b000;
    if (ack_i !== 1'b1) begin
      $display("Error ack expected 1 seen %b", ack_i);
      testbench.fails++;
      testbench.test_done();
    end
  endtask : xfer
endmodule : chgirq_host
`default_nettype wire

// [dv/testbench.sv]
// Self-checking bench for the charger interrupt status and mask block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam logic [9:0] A_ST = 10'h064;
  localparam logic [9:0] A_MK = 10'h084;
  localparam logic [9:0] A_PD = 10'h088;
  localparam logic [9:0] A_LV = 10'h08c;
  logic        clk;
  logic        rst_n;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [9:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic        irq;
  logic        b31;
  logic        b285;
  logic [13:0] oth;
  logic [31:0] v;
  int          fails;
  int          tests_run;

  chgirq_top chgirq_top_inst (.SYS_CLK_I(clk), .RESET_N_I(rst_n), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
    .WB_DAT_O(rdat), .WB_ACK_O(ack), .BATT_BELOW_3V1_I(b31),
    .BATT_BELOW_2V85_I(b285), .CHG_OTHER_COND_I(oth), .CHARGER_SUMMARY_IRQ_O(irq));

  chgirq_host chgirq_host_inst (.clk_i(clk), .cyc_o(cyc), .stb_o(stb), .we_o(we),
    .adr_o(adr), .sel_o(sel), .dat_o(wdat), .dat_i(rdat), .ack_i(ack));

  always #25 clk = ~clk;

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic rd(input logic [9:0] a, input logic [31:0] exp);
    chgirq_host_inst.xfer(1'b0, a, 4'hf, 32'h0, v);
    chk("read data", v, exp);
  endtask : rd

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    chgirq_host_inst.xfer(1'b1, a, 4'hf, d, v);
  endtask : wr

  task automatic wr_sel(input logic [9:0] a, input logic [31:0] d, input logic [3:0] s);
    chgirq_host_inst.xfer(1'b1, a, s, d, v);
  endtask : wr_sel

  // Irq is sampled at an edge, so it shows the previous cycle's settled value
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    b31 = 1'b0;
    b285 = 1'b0;
    oth = '0;
    fails = 0;
    tests_run = 0;
    tick(12);
    rst_n <= 1'b1;
    rd(A_MK, 32'h0000_ffff);
    rd(A_ST, 32'h0);
    chk("irq", irq, 1'b0);
    $display("test reset done");
    // Masked event still latches
    @(posedge clk);
    b31 <= 1'b1;
    tick(2);
    chk("irq", irq, 1'b0);
    rd(A_ST, 32'h2);
    rd(A_ST, 32'h0);
    $display("test masked latch done");
    wr(A_MK, 32'hfffc);
    rd(A_MK, 32'hfffc);
    chk("irq", irq, 1'b0);
    @(posedge clk);
    b285 <= 1'b1;
    tick(2);
    chk("irq", irq, 1'b1);
    rd(A_ST, 32'h1);
    chk("irq", irq, 1'b0);
    tick(3);
    rd(A_ST, 32'h0);
    $display("test unmasked event done");
    @(posedge clk);
    b31 <= 1'b0;
    @(posedge clk);
    b31 <= 1'b1;
    tick(2);
    chk("irq", irq, 1'b1);
    wr(A_MK, 32'hffff);
    chk("irq", irq, 1'b0);
    rd(A_ST, 32'h2);
    $display("test mask off done");
    @(posedge clk);
    oth <= 14'h3fff;
    tick(2);
    chk("irq", irq, 1'b0);
    wr(A_MK, 32'h7fff);
    chk("irq", irq, 1'b1);
    rd(A_ST, 32'hfffc);
    chk("irq", irq, 1'b0);
    rd(10'h3f0, 32'h0);
    $display("test high bits done");
    rd(A_LV, 32'h0000_ffff);
    @(posedge clk);
    b285 <= 1'b0;
    @(posedge clk);
    b285 <= 1'b1;
    tick(2);
    rd(A_PD, 32'h0);
    wr(A_MK, 32'h7ffe);
    rd(A_PD, 32'h1);
    chk("irq", irq, 1'b1);
    wr(A_ST, 32'h1);
    chk("irq", irq, 1'b0);
    rd(A_ST, 32'h0);
    wr_sel(A_MK, 32'h0000_00ff, 4'h2);
    rd(A_MK, 32'h0000_00fe);
    $display("test registers done");
    // An edge in the read cycle must survive the read clear
    @(posedge clk);
    b31 <= 1'b0;
    b285 <= 1'b0;
    @(posedge clk);
    b285 <= 1'b1;
    tick(2);
    fork
      rd(A_ST, 32'h1);
      begin
        @(posedge clk);
        b31 <= 1'b1;
      end
    join
    chk("irq", irq, 1'b0);
    rd(A_ST, 32'h2);
    $display("test set wins done");
    // Conditions already high at release count as edges
    @(posedge clk);
    rst_n <= 1'b0;
    tick(2);
    rst_n <= 1'b1;
    rd(A_MK, 32'h0000_ffff);
    rd(A_ST, 32'h0000_ffff);
    chk("irq", irq, 1'b0);
    $display("test mid reset done");
    test_done();
  end
endmodule : testbench
`default_nettype wire
